// *** include/pin_mux_pkg.sv ***
// pin_mux_pkg: reset values, pin positions and field codes for the port pin function mux
// assumes one clock domain and software-visible configuration bits arriving as plain ports
package pin_mux_pkg;
   // register widths
   localparam int P3_WIDTH = 8;
   localparam int P4_WIDTH = 5;
   // reset values
   localparam logic P2_SEL7_RESET = 1'b1;
   localparam logic P2_DIR7_RESET = 1'b0;
   localparam logic [7:0] P3_SEL_RESET = 8'h00;
   localparam logic [7:0] P3_DIR_RESET = 8'h00;
   localparam logic [4:0] P4_SEL_RESET = 5'h00;
   localparam logic [4:0] P4_DIR_RESET = 5'h00;
   localparam logic [2:0] AE_FIRST_RESET = 3'h0;
   localparam logic [1:0] AE_SECOND_RESET = 2'h0;
   // third-port pin positions
   localparam int P3_SER0_CLK_BIT = 0;
   localparam int P3_SER1_CLK_BIT = 3;
   localparam int P3_SERIAL_LAST = 5;
   localparam int P3_ANA_A_BIT = 0;
   localparam int P3_ANA_B_BIT = 6;
   localparam int P3_ANA_C_BIT = 7;
   // fourth-port pin positions
   localparam int P4_SET_B_FIRST = 3;
   // amplifier fields
   localparam logic [1:0] AMP_ROUTE_INTERNAL = 2'h3;
   localparam logic [2:0] AMP_FUNC_OFF = 3'h0;
   // mode of a pin, for visibility
   typedef enum logic [1:0] {
      PIN_GPIO = 2'b00,
      PIN_PERIPH = 2'b01,
      PIN_ANALOG = 2'b10,
      PIN_OSC = 2'b11
   } pin_mode_t;
endpackage

// *** design/port_pin_function_mux.sv ***
// port_pin_function_mux: function selection for port pins 2.7, 3.0-3.7 and 4.0-4.4
// assumes configuration ports are driven by software-written registers elsewhere,
// pads are split into in/out/oe, and serial/timer/oscillator modules sit beside it
//
// Summary of operation
// [RULE1] After reset the second port bit 7 select is set so the pad carries the crystal drive output until cleared.
// [RULE2] All other pins reset to general I/O with select and analog enable zero, direction 0 input and 1 output.
// [RULE3] With select set on third-port bits 0 to 5 the serial module, not the direction bit, decides pad drive.
// [RULE4] On third-port bit 0 the first serial clock wins over the second slave enable, forcing the second unit to 3-wire.
// [RULE5] On third-port bit 3 the second serial clock wins over the first slave enable, forcing the first unit to 3-wire.
// [RULE6] First analog enable on third-port bits 0, 6 or 7 makes the pin analog and disables driver and input buffer.
// [RULE7] Second analog enable on fourth-port bits 3 or 4 makes the pin analog and disables driver and input buffer.
// [RULE8] Amplifier routing 11 with function not 000 ties converter inputs 12 and 13 to amplifier outputs, cutting the pad.
// [RULE9] Fourth-port bits 0 to 2 with select set feed timer capture set A on direction 0 and drive compare on direction 1.
// [RULE10] Fourth-port bits 3 and 4 with select set and analog off feed capture set B or drive compare outputs.
// [RULE11] The mux is combinational from the current settings, so a change shows on the pad the cycle after the write.
`timescale 1ns/1ps
module port_pin_function_mux
   import pin_mux_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   input wire logic power_up_clear_reset,
   // software configuration writes
   input wire logic cfg_write,
   input wire logic port2_function_select_in,
   input wire logic port2_direction_in,
   input wire logic [7:0] port3_function_select_in,
   input wire logic [7:0] port3_direction_in,
   input wire logic [4:0] port4_function_select_in,
   input wire logic [4:0] port4_direction_in,
   input wire logic [2:0] analog_enable_first_in,
   input wire logic [1:0] analog_enable_second_in,
   input wire logic [1:0] amp_converter_routing_0,
   input wire logic [2:0] amp_function_config_0,
   input wire logic [1:0] amp_converter_routing_1,
   input wire logic [2:0] amp_function_config_1,
   // configuration readback
   output logic port2_function_select,
   output logic [7:0] port3_function_select,
   output logic [4:0] port4_function_select,
   // general I/O side
   input wire logic port2_out_bit7,
   output logic port2_in_bit7,
   input wire logic [7:0] port3_out,
   output logic [7:0] port3_in,
   input wire logic [4:0] port4_out,
   output logic [4:0] port4_in,
   // oscillator
   input wire logic crystal_drive_output,
   input wire logic crystal_drive_enable,
   // serial units (out, enable, in per pin 3.0..3.5)
   input wire logic [5:0] serial_pad_out,
   input wire logic [5:0] serial_pad_oe,
   output logic [5:0] serial_pad_in,
   output logic serial0_clock_in,
   output logic serial1_slave_enable_in,
   output logic serial1_clock_in,
   output logic serial0_slave_enable_in,
   output logic serial0_force_3wire,
   output logic serial1_force_3wire,
   input wire logic serial0_clock_used,
   input wire logic serial1_clock_used,
   // timer
   input wire logic [2:0] timer_compare_out,
   output logic [2:0] timer_capture_in_set_a,
   output logic [1:0] timer_capture_in_set_b,
   // analog
   output logic [1:0] converter_internal_amp,
   output logic [1:0] amp_pad_connect,
   output logic [2:0] port3_analog_active,
   output logic [1:0] port4_analog_active,
   // pads
   input wire logic pad2_7_in,
   output logic pad2_7_out,
   output logic pad2_7_oe,
   input wire logic [7:0] pad3_in,
   output logic [7:0] pad3_out,
   output logic [7:0] pad3_oe,
   input wire logic [4:0] pad4_in,
   output logic [4:0] pad4_out,
   output logic [4:0] pad4_oe
);

   ////////////////////////////////////////////////////////////////////////////
   // configuration registers

   logic reset_any;
   logic p2_sel_reg, p2_dir_reg;
   logic [7:0] p3_sel_reg, p3_dir_reg;
   logic [4:0] p4_sel_reg, p4_dir_reg;
   logic [2:0] ae1_reg;
   logic [1:0] ae2_reg;

   // power-up clear acts as a second asynchronous source
   assign reset_any = rst | power_up_clear_reset;

   always_ff @(posedge core_clk or posedge reset_any) begin
      if (reset_any) begin
         p2_sel_reg <= P2_SEL7_RESET; // RULE1
         p2_dir_reg <= P2_DIR7_RESET;
         p3_sel_reg <= P3_SEL_RESET; // RULE2
         p3_dir_reg <= P3_DIR_RESET;
         p4_sel_reg <= P4_SEL_RESET;
         p4_dir_reg <= P4_DIR_RESET;
         ae1_reg <= AE_FIRST_RESET;
         ae2_reg <= AE_SECOND_RESET;
      end else if (cfg_write) begin // RULE11
         p2_sel_reg <= port2_function_select_in;
         p2_dir_reg <= port2_direction_in;
         p3_sel_reg <= port3_function_select_in;
         p3_dir_reg <= port3_direction_in;
         p4_sel_reg <= port4_function_select_in;
         p4_dir_reg <= port4_direction_in;
         ae1_reg <= analog_enable_first_in;
         ae2_reg <= analog_enable_second_in;
      end
   end

   assign port2_function_select = p2_sel_reg;
   assign port3_function_select = p3_sel_reg;
   assign port4_function_select = p4_sel_reg;

   ////////////////////////////////////////////////////////////////////////////
   // second port bit 7

   // oscillator owns the pad while selected; driver may be off when stopped
   assign pad2_7_oe = p2_sel_reg ? crystal_drive_enable : p2_dir_reg; // RULE1
   assign pad2_7_out = p2_sel_reg ? crystal_drive_output : port2_out_bit7;
   assign port2_in_bit7 = pad2_7_in;

   ////////////////////////////////////////////////////////////////////////////
   // third port

   logic [7:0] p3_ana;
   logic [7:0] p3_ser;
   assign p3_ana = {ae1_reg[2], ae1_reg[1], 5'h00, ae1_reg[0]};
   assign p3_ser = {2'b00, p3_sel_reg[5:0]};
   assign port3_analog_active = ae1_reg;

   genvar g;
   generate
      for (g = 0; g < P3_WIDTH; g++) begin : g_p3
         // analog wins, then serial, then plain I/O
         assign pad3_oe[g] = p3_ana[g] ? 1'b0 : // RULE6
            (p3_ser[g] ? serial_pad_oe[g] : p3_dir_reg[g]); // RULE3 RULE2
         assign pad3_out[g] = p3_ser[g] ? serial_pad_out[g] : port3_out[g];
         // input buffer off in analog mode keeps cross current out
         assign port3_in[g] = p3_ana[g] ? 1'b0 : pad3_in[g]; // RULE6
      end
      for (g = 0; g <= P3_SERIAL_LAST; g++) begin : g_ser
         assign serial_pad_in[g] = (p3_ser[g] && !p3_ana[g]) ? pad3_in[g] : 1'b0; // RULE3
      end
   endgenerate

   logic pin0_clock, pin3_clock;
   assign pin0_clock = p3_ser[P3_SER0_CLK_BIT] && !p3_ana[P3_SER0_CLK_BIT] && serial0_clock_used;
   assign pin3_clock = p3_ser[P3_SER1_CLK_BIT] && serial1_clock_used;
   assign serial0_clock_in = serial_pad_in[P3_SER0_CLK_BIT];
   // slave enable held inactive-high when its pin is taken by the other clock
   assign serial1_slave_enable_in = pin0_clock ? 1'b1 : serial_pad_in[P3_SER0_CLK_BIT]; // RULE4
   assign serial1_force_3wire = pin0_clock; // RULE4
   assign serial1_clock_in = serial_pad_in[P3_SER1_CLK_BIT];
   assign serial0_slave_enable_in = pin3_clock ? 1'b1 : serial_pad_in[P3_SER1_CLK_BIT]; // RULE5
   assign serial0_force_3wire = pin3_clock; // RULE5

   ////////////////////////////////////////////////////////////////////////////
   // fourth port

   logic [4:0] p4_ana;
   logic [4:0] p4_tmr;
   logic [4:0] p4_cmp;
   assign p4_ana = {ae2_reg, 3'h0};
   assign port4_analog_active = ae2_reg;
   assign p4_tmr = p4_sel_reg & ~p4_ana;
   assign p4_cmp = {timer_compare_out[1:0], timer_compare_out};

   // timer drives on direction 1, plain I/O otherwise; analog overrides all
   assign pad4_oe = p4_ana_off(p4_ana) & p4_dir_reg; // RULE7 RULE9 RULE10
   assign pad4_out = (p4_tmr & p4_cmp) | (~p4_tmr & port4_out); // RULE9 RULE10
   assign port4_in = ~p4_ana & pad4_in; // RULE7
   assign timer_capture_in_set_a = pad4_in[2:0] & p4_tmr[2:0] & ~p4_dir_reg[2:0]; // RULE9
   assign timer_capture_in_set_b = pad4_in[4:3] & p4_tmr[4:3] & ~p4_dir_reg[4:3]; // RULE10

   function automatic logic [4:0] p4_ana_off(input logic [4:0] ana);
      p4_ana_off = ~ana;
   endfunction

   function automatic logic amp_internal(input logic [1:0] route, input logic [2:0] func);
      amp_internal = (route == AMP_ROUTE_INTERNAL) && (func != AMP_FUNC_OFF);
   endfunction

   assign converter_internal_amp[0] = amp_internal(amp_converter_routing_0, amp_function_config_0); // RULE8
   assign converter_internal_amp[1] = amp_internal(amp_converter_routing_1, amp_function_config_1); // RULE8
   assign amp_pad_connect = ae2_reg & ~converter_internal_amp; // RULE8

   ////////////////////////////////////////////////////////////////////////////
   // checks

   a_osc_after_reset: assert property (@(posedge core_clk) $fell(reset_any) |-> p2_sel_reg) // RULE1
      else $error("oscillator select not set after reset");
   a_gpio_dir_out: assert property (@(posedge core_clk) disable iff (reset_any)
      (!p3_ser[4] && !p3_ana[4]) |-> pad3_oe[4] == p3_dir_reg[4]) // RULE2
      else $error("plain io direction wrong");
   a_serial_owns_oe: assert property (@(posedge core_clk) disable iff (reset_any)
      (p3_ser[2]) |-> pad3_oe[2] == serial_pad_oe[2]) // RULE3
      else $error("serial pad enable not honoured");
   a_clk0_forces: assert property (@(posedge core_clk) disable iff (reset_any)
      pin0_clock |-> serial1_force_3wire && serial1_slave_enable_in) // RULE4
      else $error("second unit not forced to 3-wire");
   a_clk1_forces: assert property (@(posedge core_clk) disable iff (reset_any)
      pin3_clock |-> serial0_force_3wire && serial0_slave_enable_in) // RULE5
      else $error("first unit not forced to 3-wire");
   a_p3_analog_off: assert property (@(posedge core_clk) disable iff (reset_any)
      ae1_reg[1] |-> !pad3_oe[6] && !port3_in[6]) // RULE6
      else $error("third port analog pin still digital");
   a_p4_analog_off: assert property (@(posedge core_clk) disable iff (reset_any)
      ae2_reg[0] |-> !pad4_oe[3] && !port4_in[3] && timer_capture_in_set_b[0] == 1'b0) // RULE7
      else $error("fourth port analog pin still digital");
   a_amp_internal: assert property (@(posedge core_clk) disable iff (reset_any)
      (amp_converter_routing_0 == 2'h3 && amp_function_config_0 != 3'h0) |-> !amp_pad_connect[0]) // RULE8
      else $error("amplifier pad not cut");
   a_timer_a_drive: assert property (@(posedge core_clk) disable iff (reset_any)
      (p4_sel_reg[1] && p4_dir_reg[1]) |-> pad4_oe[1] && pad4_out[1] == timer_compare_out[1]) // RULE9
      else $error("timer compare not on pad");
   a_timer_b_cap: assert property (@(posedge core_clk) disable iff (reset_any)
      (p4_sel_reg[4] && !p4_dir_reg[4] && !ae2_reg[1]) |-> timer_capture_in_set_b[1] == pad4_in[4]) // RULE10
      else $error("capture set b not fed");
   // compare against the values written, not whatever the inputs show a cycle later
   a_write_next_cycle: assert property (@(posedge core_clk) disable iff (reset_any)
      cfg_write |=> pad3_oe[7] == ($past(port3_direction_in[7]) & ~$past(analog_enable_first_in[2]))) // RULE11
      else $error("write not seen next cycle");
   a_config_held: assert property (@(posedge core_clk) disable iff (reset_any)
      !cfg_write |=> $stable(p3_sel_reg) && $stable(p3_dir_reg) && $stable(p4_sel_reg)) // RULE11
      else $error("configuration moved without a write");
   a_osc_pad_drive: assert property (@(posedge core_clk) disable iff (reset_any)
      p2_sel_reg |-> pad2_7_out == crystal_drive_output && pad2_7_oe == crystal_drive_enable) // RULE1
      else $error("oscillator not on its pad");
   a_p2_gpio: assert property (@(posedge core_clk) disable iff (reset_any)
      !p2_sel_reg |-> pad2_7_oe == p2_dir_reg && pad2_7_out == port2_out_bit7) // RULE2
      else $error("second port pin not plain io");
   a_p2_readback: assert property (@(posedge core_clk) disable iff (reset_any)
      port2_in_bit7 == pad2_7_in) // RULE2
      else $error("second port pin readback wrong");
   a_p3_gpio_out: assert property (@(posedge core_clk) disable iff (reset_any)
      (!p3_ser[0] && !p3_ana[0]) |-> pad3_out[0] == port3_out[0] && pad3_oe[0] == p3_dir_reg[0]) // RULE2
      else $error("third port pin 0 not plain io");
   a_serial_out: assert property (@(posedge core_clk) disable iff (reset_any)
      p3_sel_reg[5] |-> pad3_out[5] == serial_pad_out[5]) // RULE3
      else $error("serial data not on pad");
   a_serial_in_gate: assert property (@(posedge core_clk) disable iff (reset_any)
      !p3_sel_reg[1] |-> !serial_pad_in[1]) // RULE3
      else $error("serial input not gated");
   a_serial_in_pass: assert property (@(posedge core_clk) disable iff (reset_any)
      p3_sel_reg[4] |-> serial_pad_in[4] == pad3_in[4]) // RULE3
      else $error("serial input not passed");
   a_clk0_feed: assert property (@(posedge core_clk) disable iff (reset_any)
      pin0_clock |-> serial0_clock_in == pad3_in[0]) // RULE4
      else $error("first serial clock not fed");
   a_ste1_pass: assert property (@(posedge core_clk) disable iff (reset_any)
      !pin0_clock |-> !serial1_force_3wire && serial1_slave_enable_in == serial_pad_in[0]) // RULE4
      else $error("second slave enable not passed");
   a_clk1_feed: assert property (@(posedge core_clk) disable iff (reset_any)
      pin3_clock |-> serial1_clock_in == pad3_in[3]) // RULE5
      else $error("second serial clock not fed");
   a_ste0_pass: assert property (@(posedge core_clk) disable iff (reset_any)
      !pin3_clock |-> !serial0_force_3wire && serial0_slave_enable_in == serial_pad_in[3]) // RULE5
      else $error("first slave enable not passed");
   a_p3_pin0_analog: assert property (@(posedge core_clk) disable iff (reset_any)
      ae1_reg[0] |-> !pad3_oe[0] && !port3_in[0] && !serial_pad_in[0]) // RULE6
      else $error("third port pin 0 still digital");
   a_p3_pin7_analog: assert property (@(posedge core_clk) disable iff (reset_any)
      ae1_reg[2] |-> !pad3_oe[7] && !port3_in[7]) // RULE6
      else $error("third port pin 7 still digital");
   a_p4_pin4_analog: assert property (@(posedge core_clk) disable iff (reset_any)
      ae2_reg[1] |-> !pad4_oe[4] && !port4_in[4] && !timer_capture_in_set_b[1]) // RULE7
      else $error("fourth port pin 4 still digital");
   a_amp1_internal: assert property (@(posedge core_clk) disable iff (reset_any)
      (amp_converter_routing_1 == 2'h3 && amp_function_config_1 != 3'h0) |-> !amp_pad_connect[1]) // RULE8
      else $error("second amplifier pad not cut");
   a_amp_off_route: assert property (@(posedge core_clk) disable iff (reset_any)
      amp_function_config_0 == 3'h0 |-> !converter_internal_amp[0]) // RULE8
      else $error("amplifier routed while off");
   a_timer_a_cap: assert property (@(posedge core_clk) disable iff (reset_any)
      (p4_sel_reg[0] && !p4_dir_reg[0]) |-> timer_capture_in_set_a[0] == pad4_in[0] && !pad4_oe[0]) // RULE9
      else $error("capture set a not fed");
   a_timer_a_idle: assert property (@(posedge core_clk) disable iff (reset_any)
      !p4_sel_reg[2] |-> !timer_capture_in_set_a[2] && pad4_out[2] == port4_out[2]) // RULE9
      else $error("timer path active while deselected");
   a_timer_b_drive: assert property (@(posedge core_clk) disable iff (reset_any)
      (p4_sel_reg[3] && p4_dir_reg[3] && !ae2_reg[0]) |-> pad4_oe[3] && pad4_out[3] == timer_compare_out[0]) // RULE10
      else $error("set b compare not on pad");

   c_osc_released: cover property (@(posedge core_clk) disable iff (reset_any) $fell(p2_sel_reg));
   c_clk0_used: cover property (@(posedge core_clk) disable iff (reset_any) pin0_clock);
   c_analog_p4: cover property (@(posedge core_clk) disable iff (reset_any) ae2_reg == 2'h3);
   c_timer_drive: cover property (@(posedge core_clk) disable iff (reset_any) p4_tmr[0] && p4_dir_reg[0]);
   c_clk1_used: cover property (@(posedge core_clk) disable iff (reset_any) pin3_clock);

endmodule

// *** dv/serial_timer_osc_model.sv ***
// serial_timer_osc_model: behavioural serial units, timer and oscillator beside the pin mux
// assumes the bench asks for pad enables and clock use; crystal drive enable is tied high, the rest free-runs
`timescale 1ns/1ps
module serial_timer_osc_model (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // bench requests
   input wire logic [5:0] oe_req,
   input wire logic [1:0] use_req,
   // toward the mux
   output logic crystal_drive_output,
   output logic crystal_drive_enable,
   output logic [5:0] serial_pad_out,
   output logic [5:0] serial_pad_oe,
   output logic serial0_clock_used,
   output logic serial1_clock_used,
   output logic [2:0] timer_compare_out
);
   logic [5:0] cnt_reg;
   // data keeps moving so a stuck pad path cannot hide
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cnt_reg <= 6'h00;
      end else begin
         cnt_reg <= cnt_reg + 6'h01;
      end
   end
   assign crystal_drive_output = cnt_reg[0];
   assign crystal_drive_enable = 1'b1;
   assign serial_pad_out = ~cnt_reg;
   assign serial_pad_oe = oe_req;
   assign {serial1_clock_used, serial0_clock_used} = use_req;
   assign timer_compare_out = cnt_reg[3:1];
endmodule

// *** dv/port_pin_function_mux_tb_top.sv ***
// port_pin_function_mux_tb_top: directed tests of the port pin function mux
// assumes the peripheral model beside it and config loaded by a one-cycle write strobe
`timescale 1ns/1ps
module port_pin_function_mux_tb_top;
   import pin_mux_pkg::*;
   logic core_clk, rst, power_up_clear_reset, cfg_write, port2_function_select_in, port2_direction_in;
   logic [7:0] port3_function_select_in, port3_direction_in, port3_out, pad3_in, port3_function_select, port3_in;
   logic [4:0] port4_function_select_in, port4_direction_in, port4_out, pad4_in, port4_function_select, port4_in;
   logic [2:0] analog_enable_first_in, amp_function_config_0, amp_function_config_1, timer_compare_out;
   logic [1:0] analog_enable_second_in, amp_converter_routing_0, amp_converter_routing_1, use_req;
   logic port2_out_bit7, pad2_7_in, port2_function_select, port2_in_bit7, crystal_drive_output;
   logic crystal_drive_enable, serial0_clock_in, serial1_slave_enable_in, serial1_clock_in;
   logic serial0_slave_enable_in, serial0_force_3wire, serial1_force_3wire, serial0_clock_used, serial1_clock_used;
   logic [5:0] serial_pad_out, serial_pad_oe, serial_pad_in, oe_req;
   logic [2:0] timer_capture_in_set_a, port3_analog_active;
   logic [1:0] timer_capture_in_set_b, converter_internal_amp, amp_pad_connect, port4_analog_active;
   logic pad2_7_out, pad2_7_oe;
   logic [7:0] pad3_out, pad3_oe;
   logic [4:0] pad4_out, pad4_oe;
   int mismatches = 0;
   int num_checks = 0;

   port_pin_function_mux u_port_pin_function_mux (.core_clk, .rst, .power_up_clear_reset, .cfg_write,
      .port2_function_select_in, .port2_direction_in, .port3_function_select_in, .port3_direction_in,
      .port4_function_select_in, .port4_direction_in, .analog_enable_first_in, .analog_enable_second_in,
      .amp_converter_routing_0, .amp_function_config_0, .amp_converter_routing_1, .amp_function_config_1,
      .port2_function_select, .port3_function_select, .port4_function_select, .port2_out_bit7, .port2_in_bit7,
      .port3_out, .port3_in, .port4_out, .port4_in, .crystal_drive_output, .crystal_drive_enable,
      .serial_pad_out, .serial_pad_oe, .serial_pad_in, .serial0_clock_in, .serial1_slave_enable_in,
      .serial1_clock_in, .serial0_slave_enable_in, .serial0_force_3wire, .serial1_force_3wire,
      .serial0_clock_used, .serial1_clock_used, .timer_compare_out, .timer_capture_in_set_a,
      .timer_capture_in_set_b, .converter_internal_amp, .amp_pad_connect, .port3_analog_active,
      .port4_analog_active, .pad2_7_in, .pad2_7_out, .pad2_7_oe, .pad3_in, .pad3_out, .pad3_oe, .pad4_in,
      .pad4_out, .pad4_oe);
   serial_timer_osc_model u_serial_timer_osc_model (.core_clk, .rst, .oe_req, .use_req, .crystal_drive_output,
      .crystal_drive_enable, .serial_pad_out, .serial_pad_oe, .serial0_clock_used, .serial1_clock_used,
      .timer_compare_out);

   ////////////////////////////////////////////////////////////////////////
   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // select, direction and analog enable settings go in with one strobe; result read after the next edge
   task wr(input logic [1:0] p2, input logic [7:0] s3, d3, input logic [4:0] s4, d4, ae);
      @(posedge core_clk);
      cfg_write <= 1'b1;
      {port2_function_select_in, port2_direction_in} <= p2;
      {port3_function_select_in, port3_direction_in} <= {s3, d3};
      {port4_function_select_in, port4_direction_in} <= {s4, d4};
      {analog_enable_second_in, analog_enable_first_in} <= ae;
      @(posedge core_clk);
      cfg_write <= 1'b0;
      #1;
   endtask

   task stop_test;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   initial begin
      repeat (1000) @(posedge core_clk);
      mismatches++;
      stop_test;
   end

   initial begin
      {rst, power_up_clear_reset, cfg_write} = 3'b110;
      {port2_function_select_in, port2_direction_in, port3_function_select_in, port3_direction_in} = 18'h0;
      {port4_function_select_in, port4_direction_in, analog_enable_first_in, analog_enable_second_in} = 15'h0;
      {amp_converter_routing_0, amp_function_config_0, amp_converter_routing_1, amp_function_config_1} = 10'h0;
      {port2_out_bit7, pad2_7_in, port3_out, pad3_in, port4_out, pad4_in} = {2'b10, 8'h9C, 8'h52, 5'h16, 5'h0A};
      {oe_req, use_req} = {6'h15, 2'b00};
      repeat (20) @(posedge core_clk);
      {rst, power_up_clear_reset} <= 2'b00;
      @(posedge core_clk);
      #1;
      chk(port2_function_select, 1'b1);
      chk({pad2_7_oe, pad2_7_out}, {1'b1, crystal_drive_output});
      chk({port4_function_select, port3_function_select, pad4_oe, pad3_oe}, 32'h0000_0000);
      chk({port2_in_bit7, port4_in}, {pad2_7_in, pad4_in});
      wr(2'b01, 8'h00, 8'hC3, 5'h00, 5'h15, 5'h00);
      chk({pad2_7_oe, pad2_7_out}, {1'b1, port2_out_bit7});
      chk({pad4_oe, pad3_oe}, {5'h15, 8'hC3});
      chk({pad3_out & 8'hC3, port3_in & 8'h3C}, {port3_out & 8'hC3, pad3_in & 8'h3C});
      wr(2'b00, 8'h3F, 8'hFF, 5'h00, 5'h00, 5'h00);
      chk({pad3_oe, pad3_out[5:0] & 6'h15}, {8'hD5, serial_pad_out & 6'h15});
      chk(serial_pad_in, pad3_in[5:0]);
      wr(2'b00, 8'h3F, 8'h00, 5'h00, 5'h00, 5'h00);
      chk(pad3_oe, 8'h15);
      chk({serial1_slave_enable_in, serial0_slave_enable_in, serial0_force_3wire, serial1_force_3wire},
         {pad3_in[0], pad3_in[3], 2'b00});
      @(posedge core_clk);
      use_req <= 2'b01;
      #1;
      chk({serial1_force_3wire, serial1_slave_enable_in, serial0_clock_in}, {2'b11, pad3_in[0]});
      @(posedge core_clk);
      use_req <= 2'b10;
      #1;
      chk({serial0_force_3wire, serial0_slave_enable_in, serial1_clock_in}, {2'b11, pad3_in[3]});
      wr(2'b00, 8'hFF, 8'hFF, 5'h00, 5'h00, 5'h07);
      chk({port3_analog_active, pad3_oe & 8'hC1, port3_in & 8'hC1}, {3'h7, 16'h0000});
      chk(serial_pad_in[0], 1'b0);
      wr(2'b00, 8'h00, 8'h00, 5'h1F, 5'h07, 5'h00);
      chk({pad4_oe, pad4_out[2:0], timer_capture_in_set_b}, {5'h07, timer_compare_out, pad4_in[4:3]});
      wr(2'b00, 8'h00, 8'h00, 5'h1F, 5'h18, 5'h00);
      chk({pad4_oe, timer_capture_in_set_a}, {5'h18, pad4_in[2:0]});
      chk(pad4_out[4:3], timer_compare_out[1:0]);
      wr(2'b00, 8'h00, 8'h00, 5'h1F, 5'h1F, 5'h18);
      chk({pad4_oe, port4_analog_active, timer_capture_in_set_b, port4_in[4:3]}, {5'h07, 2'h3, 4'h0});
      @(posedge core_clk);
      {amp_converter_routing_0, amp_function_config_0} <= {AMP_ROUTE_INTERNAL, 3'h1};
      {amp_converter_routing_1, amp_function_config_1} <= {AMP_ROUTE_INTERNAL, AMP_FUNC_OFF};
      #1;
      chk({converter_internal_amp, amp_pad_connect[0]}, 3'b010);
      @(posedge core_clk);
      amp_converter_routing_0 <= 2'h2;
      #1;
      chk(converter_internal_amp, 2'b00);
      @(posedge core_clk);
      power_up_clear_reset <= 1'b1;
      @(posedge core_clk);
      power_up_clear_reset <= 1'b0;
      #1;
      chk({port2_function_select, port4_function_select, port4_analog_active}, 8'h80);
      stop_test;
   end
endmodule
